// ===== dac_serial_pkg.sv
/*
 package of constants and carrier types for the serial dac write port.
 assumes a 16-bit frame, msb first, sampled on falling serial clock edges.
*/
// Summary of operation
// - low frame select enables the shift register
// - sample data on each of the first sixteen falling serial clocks
// - shift register holds exactly sixteen bits
// - sixteenth falling edge updates dac and mode
// - early frame select rise aborts the frame
// - top two bits select power mode
// - abort clears shift register, keeps outputs
// - power-up dac register holds all zeros
package dac_serial_pkg;
   localparam int unsigned  WORD_BITS  = 16;
   localparam int unsigned  MODE_BITS  = 2;
   localparam int unsigned  CODE_BITS  = WORD_BITS - MODE_BITS;
   localparam int unsigned  CNT_BITS   = 5;
   localparam logic [4:0]   CNT_ZERO   = 5'h00;
   localparam logic [4:0]   CNT_ONE    = 5'h01;
   localparam logic [4:0]   CNT_LAST   = 5'h0F;
   localparam logic [15:0]  WORD_ZERO  = 16'h0000;
   localparam logic [1:0]   SYNC_IDLE  = 2'h3;

   typedef enum logic [1:0]
   {
      PWR_NORMAL = 2'h0,
      PWR_DOWN_A = 2'h1,
      PWR_DOWN_B = 2'h2,
      PWR_DOWN_C = 2'h3
   } pwr_mode_t;

   typedef struct packed
   {
      pwr_mode_t         mode;
      logic [13:0]       code;
   } dac_word_t;

   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'h0,
      ST_SHIFT = 2'h1,
      ST_DONE  = 2'h3
   } frame_state_t;
endpackage : dac_serial_pkg

// ===== dac_serial_write_port.sv
/*
 serial write port of a single channel dac: frame select, serial clock, data.
 assumes mclk is well above twice the serial clock; pins are asynchronous.
*/
`timescale 1ns/1ps
module dac_serial_write_port
(
   input  wire logic                    mclk,
   input  wire logic                    rstn,
   input  wire logic                    sync_n,
   input  wire logic                    sclk,
   input  wire logic                    din,
   output dac_serial_pkg::dac_word_t    dac_reg,
   output logic                         dac_update
);
   logic                                rst_meta_n;
   logic                                rst_n;
   logic [1:0]                          sync_pipe;
   logic [1:0]                          sclk_pipe;
   logic [1:0]                          din_pipe;
   logic                                sclk_prev;
   logic [15:0]                         shift;
   logic [4:0]                          count;
   dac_serial_pkg::frame_state_t        state;
   logic                                fall;
   logic                                sel;
   logic                                shift_fall;
   logic                                last_fall;

   // reset release
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_meta_n <= 1'b0;
         rst_n      <= 1'b0;
      end
      else
      begin
         rst_meta_n <= 1'b1;
         rst_n      <= rst_meta_n;
      end
   end

   // frame select synchroniser
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         sync_pipe <= dac_serial_pkg::SYNC_IDLE;
      else
         sync_pipe <= {sync_pipe[0], sync_n};
   end

   // serial clock synchroniser and edge history
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_pipe <= '0;
         sclk_prev <= 1'b0;
      end
      else
      begin
         sclk_pipe <= {sclk_pipe[0], sclk};
         sclk_prev <= sclk_pipe[1];
      end
   end

   // serial data synchroniser, same depth as the clock path
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         din_pipe <= '0;
      else
         din_pipe <= {din_pipe[0], din};
   end

   assign sel        = ~sync_pipe[1];
   assign fall       = sclk_prev & ~sclk_pipe[1];
   assign shift_fall = (state == dac_serial_pkg::ST_SHIFT) & sel & fall;
   assign last_fall  = shift_fall & (count == dac_serial_pkg::CNT_LAST);

   // frame state: idle, shifting, done until select rises again
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         state <= dac_serial_pkg::ST_IDLE;
      else
      begin
         case (state)
            dac_serial_pkg::ST_IDLE:
            begin
               if (sel)
                  state <= dac_serial_pkg::ST_SHIFT;
            end
            dac_serial_pkg::ST_SHIFT:
            begin
               if (!sel)
                  state <= dac_serial_pkg::ST_IDLE;
               else if (last_fall)
                  state <= dac_serial_pkg::ST_DONE;
            end
            dac_serial_pkg::ST_DONE:
            begin
               if (!sel)
                  state <= dac_serial_pkg::ST_IDLE;
            end
            default:
               state <= dac_serial_pkg::ST_IDLE;
         endcase
      end
   end

   // bit counter: cleared outside a frame and on abort, held once done
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         count <= dac_serial_pkg::CNT_ZERO;
      else if (state == dac_serial_pkg::ST_IDLE || (state == dac_serial_pkg::ST_SHIFT && !sel))
         count <= dac_serial_pkg::CNT_ZERO;
      else if (shift_fall)
         count <= count + dac_serial_pkg::CNT_ONE;
   end

   // input shift register: cleared outside a frame and on abort
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         shift <= dac_serial_pkg::WORD_ZERO;
      else if (state == dac_serial_pkg::ST_IDLE || (state == dac_serial_pkg::ST_SHIFT && !sel))
         shift <= dac_serial_pkg::WORD_ZERO;
      else if (shift_fall)
         shift <= {shift[14:0], din_pipe[1]};
   end

   // dac register and mode update on the sixteenth edge
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dac_reg    <= dac_serial_pkg::WORD_ZERO;
         dac_update <= 1'b0;
      end
      else
      begin
         dac_update <= 1'b0;
         if (last_fall)
         begin
            dac_reg    <= {shift[14:0], din_pipe[1]};
            dac_update <= 1'b1;
         end
      end
   end

   // frame sequencing checks
   chk_update_on_last: assert property (@(posedge mclk) disable iff (!rst_n)
      dac_update |-> $past(count) == dac_serial_pkg::CNT_LAST && $past(fall) && $past(sel))
      else $error("update without sixteenth edge");
   chk_update_single: assert property (@(posedge mclk) disable iff (!rst_n)
      dac_update |=> !dac_update)
      else $error("update pulse longer than one cycle");
   chk_frame_start: assert property (@(posedge mclk) disable iff (!rst_n)
      (state == dac_serial_pkg::ST_IDLE && sel) |=> state == dac_serial_pkg::ST_SHIFT)
      else $error("select low did not open a frame");
   chk_idle_no_shift: assert property (@(posedge mclk) disable iff (!rst_n)
      (state == dac_serial_pkg::ST_IDLE) |=> count == dac_serial_pkg::CNT_ZERO)
      else $error("counter moved outside frame");
   chk_idle_no_update: assert property (@(posedge mclk) disable iff (!rst_n)
      (state == dac_serial_pkg::ST_IDLE) |=> !dac_update && shift == dac_serial_pkg::WORD_ZERO)
      else $error("activity outside a frame");
   chk_abort_holds: assert property (@(posedge mclk) disable iff (!rst_n)
      (state == dac_serial_pkg::ST_SHIFT && !sel) |=> $stable(dac_reg) && shift == dac_serial_pkg::WORD_ZERO)
      else $error("abort changed outputs");
   chk_abort_to_idle: assert property (@(posedge mclk) disable iff (!rst_n)
      (state == dac_serial_pkg::ST_SHIFT && !sel) |=> state == dac_serial_pkg::ST_IDLE && !dac_update)
      else $error("abort did not end the frame");
   chk_done_waits: assert property (@(posedge mclk) disable iff (!rst_n)
      (state == dac_serial_pkg::ST_DONE && sel) |=> state == dac_serial_pkg::ST_DONE && !dac_update)
      else $error("second frame without select rise");
   chk_done_ignores: assert property (@(posedge mclk) disable iff (!rst_n)
      (state == dac_serial_pkg::ST_DONE && sel && fall) |=> $stable(shift) && $stable(count))
      else $error("falls after the sixteenth were taken");
   chk_reg_stable: assert property (@(posedge mclk) disable iff (!rst_n)
      !dac_update |-> $stable(dac_reg))
      else $error("dac register changed without update");

   // data path checks
   chk_fall_single: assert property (@(posedge mclk) disable iff (!rst_n)
      fall |=> !fall)
      else $error("falling edge seen twice");
   chk_shift_on_fall: assert property (@(posedge mclk) disable iff (!rst_n)
      (state == dac_serial_pkg::ST_SHIFT && sel && fall) |=> count == $past(count) + dac_serial_pkg::CNT_ONE)
      else $error("bit not counted on falling edge");
   chk_hold_between: assert property (@(posedge mclk) disable iff (!rst_n)
      (state == dac_serial_pkg::ST_SHIFT && sel && !fall) |=> $stable(shift) && $stable(count))
      else $error("bit taken without falling edge");
   chk_count_bounded: assert property (@(posedge mclk) disable iff (!rst_n)
      (state == dac_serial_pkg::ST_SHIFT) |-> count <= dac_serial_pkg::CNT_LAST)
      else $error("more than sixteen bits in a frame");
   chk_msb_first: assert property (@(posedge mclk) disable iff (!rst_n)
      (state == dac_serial_pkg::ST_SHIFT && sel && fall) |=> shift[0] == $past(din_pipe[1])
      && shift[15:1] == $past(shift[14:0]))
      else $error("shift order wrong");
   chk_word_loaded: assert property (@(posedge mclk) disable iff (!rst_n)
      dac_update |-> dac_reg == {$past(shift[14:0]), $past(din_pipe[1])})
      else $error("loaded word differs from shifted bits");
   chk_mode_field: assert property (@(posedge mclk) disable iff (!rst_n)
      dac_update |-> dac_reg.mode == $past(shift[14:13]))
      else $error("mode bits misplaced");
   chk_code_field: assert property (@(posedge mclk) disable iff (!rst_n)
      dac_update |-> dac_reg.code == {$past(shift[12:0]), $past(din_pipe[1])})
      else $error("code bits misplaced");

   // cover points for the main scenarios
   cov_full_frame: cover property (@(posedge mclk) disable iff (!rst_n) dac_update);
   cov_abort: cover property (@(posedge mclk) disable iff (!rst_n)
      state == dac_serial_pkg::ST_SHIFT && !sel && count != dac_serial_pkg::CNT_ZERO);
   cov_powerdown: cover property (@(posedge mclk) disable iff (!rst_n)
      dac_update && dac_reg.mode != dac_serial_pkg::PWR_NORMAL);
   cov_normal_mode: cover property (@(posedge mclk) disable iff (!rst_n)
      dac_update && dac_reg.mode == dac_serial_pkg::PWR_NORMAL);
   cov_extra_falls: cover property (@(posedge mclk) disable iff (!rst_n)
      state == dac_serial_pkg::ST_DONE && sel && fall);
endmodule : dac_serial_write_port

// ===== dac_host_model.sv
/*
 host model: drives frame select, serial clock and data of the dac port.
 assumes mclk at 100 mhz; the serial clock stands high outside frames.
*/
`timescale 1ns/1ps
module dac_host_model
(
   input  wire logic mclk,
   output logic      sync_n,
   output logic      sclk,
   output logic      din
);
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick

   // nf falls; falls past sixteen stay inside the same select
   task automatic send(input logic [15:0] word, input int nf);
      sync_n = 1'b0;
      tick(4);
      for (int i = 0; i < nf; i++)
      begin
         din = (i < 16) ? word[15 - i] : ~din;
         tick(8);
         sclk = 1'b0;
         tick(8);
         sclk = 1'b1;
      end
      tick(4);
      sync_n = 1'b1;
      din    = ~din;
      tick(8);
   endtask : send

   initial
   begin
      sync_n = 1'b1;
      sclk   = 1'b1;
      din    = 1'b0;
   end
endmodule : dac_host_model

// ===== test_dac_serial_write_port.sv
/*
 testbench of the dac serial write port, driven through the host model.
 assumes the design package and host model are compiled before it.
*/
`timescale 1ns/1ps
module test_dac_serial_write_port;
   logic                      mclk;
   logic                      rstn;
   logic                      sync_n;
   logic                      sclk;
   logic                      din;
   logic                      dac_update;
   dac_serial_pkg::dac_word_t dac_reg;
   int                        err_total;
   int                        num_checks;
   int                        upd_count;

   dac_host_model host (.mclk(mclk), .sync_n(sync_n), .sclk(sclk), .din(din));
   dac_serial_write_port dut (.mclk(mclk), .rstn(rstn), .sync_n(sync_n), .sclk(sclk),
                              .din(din), .dac_reg(dac_reg), .dac_update(dac_update));

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   always @(posedge mclk)
   begin
      if (dac_update === 1'b1)
         upd_count++;
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // one frame, then word and pulse count
   task automatic frame(input logic [15:0] w, input int nf, input logic [15:0] exp, input int ups);
      host.send(w, nf);
      check("dac_reg", exp, dac_reg);
      check("update pulses", 16'(ups), 16'(upd_count));
   endtask : frame

   // power-up value before any frame
   task automatic test_power_up;
      check("dac_reg", 16'h0000, dac_reg);
      check("update pulses", 16'h0000, 16'(upd_count));
   endtask : test_power_up

   // one full frame in each power mode
   task automatic test_modes;
      for (int m = 0; m < 4; m++)
         frame({m[1:0], 14'h12B7 + 14'(m)}, 16, {m[1:0], 14'h12B7 + 14'(m)}, m + 1);
   endtask : test_modes

   // select rises after fifteen falls, then a full frame still lands
   task automatic test_abort;
      frame(16'hFFFF, 15, 16'hD2BA, 4);
      frame(16'h8001, 16, 16'h8001, 5);
   endtask : test_abort

   // thirty-two falls in one select load one word only
   task automatic test_extra_falls;
      frame(16'h4321, 32, 16'h4321, 6);
      frame(16'h7FFE, 16, 16'h7FFE, 7);
   endtask : test_extra_falls

   // reset in mid-run clears the register until a complete frame
   task automatic test_mid_reset;
      rstn = 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      check("dac_reg", 16'h0000, dac_reg);
      rstn = 1'b1;
      repeat (6) @(posedge mclk);
      #1;
      frame(16'hFFFF, 9, 16'h0000, 7);
      frame(16'h2A5C, 16, 16'h2A5C, 8);
   endtask : test_mid_reset

   task automatic complete_run;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run

   initial
   begin
      #200_000;
      err_total++;
      complete_run();
   end

   initial
   begin
      rstn = 1'b0;
      repeat (10) @(posedge mclk);
      #1;
      rstn = 1'b1;
      repeat (6) @(posedge mclk);
      #1;
      test_power_up();
      test_modes();
      test_abort();
      test_extra_falls();
      test_mid_reset();
      complete_run();
   end
endmodule : test_dac_serial_write_port
